// ==== core/rbp_pkg.sv ====
// constants and types for the reset, brownout and protection controller
package rbp_pkg;
   // ****************************************
   // register map
   // ****************************************
   localparam logic [3:0] ADR_BODCTL = 4'h0;
   localparam logic [3:0] ADR_STATUS = 4'h4;
   localparam logic [3:0] ADR_PROT = 4'h8;
   localparam logic [3:0] ADR_DEBUG = 4'hc;
   // status fields
   localparam int ST_BODIRQ = 0;
   localparam int ST_CAUSE = 4;
   // debug resources and boot address
   localparam logic [3:0] NUM_BREAK = 4'h4;
   localparam logic [3:0] NUM_WATCH = 4'h2;
   localparam logic [31:0] BOOT_ADDR = 32'h0000_0000;
   // ****************************************
   // protection patterns (values arbitrary)
   // ****************************************
   localparam logic [31:0] PAT_NO_ISP = 32'h4e49_5350;
   localparam logic [31:0] PAT_LEVEL1 = 32'h1111_5aa5;
   localparam logic [31:0] PAT_LEVEL2 = 32'h2222_5aa5;
   localparam logic [31:0] PAT_LEVEL3 = 32'h3333_5aa5;
   // ****************************************
   // timing
   // ****************************************
   localparam int CLK_NS = 10;
   localparam int PIN_PULSE_NS = 50;
   localparam int PIN_PULSE_CYC = (PIN_PULSE_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [3:0] HOLD_CYC = 4'hf;
   // ****************************************
   // types
   // ****************************************
   typedef enum logic [1:0] {
      SEQ_PWR = 2'b00,
      SEQ_INIT = 2'b01,
      SEQ_HOLD = 2'b10,
      SEQ_RUN = 2'b11
   } rbp_seq_t;
   typedef enum logic [1:0] {
      ISP_FULL = 2'b00,
      ISP_PARTIAL = 2'b01,
      ISP_ERASE_ALL = 2'b10,
      ISP_NONE = 2'b11
   } rbp_isp_t;
   typedef struct packed {
      logic irqEn;
      logic rstEn;
      logic [1:0] irqLvl;
      logic [1:0] rstLvl;
   } rbp_bodctl_t;
   localparam rbp_bodctl_t BODCTL_RST = 6'b11_00_00;
   typedef struct packed {
      logic brownout_detector;
      logic por;
      logic wdt;
      logic pin;
   } rbp_cause_t;
endpackage

// ==== core/rbp_ctrl.sv ====
// reset sequencer, brownout monitor and code read protection gate
//
// The implementer's own choices: the register offsets and the Wishbone slave port.
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - any of four sources asserts chip reset
// - reset starts fast oscillator, flash init
// - 50 ns low pin pulse resets part
// - registers defined, start address zero
// - four irq thresholds, interrupt when below
// - brownout interrupt readable in status
// - four selectable brownout reset thresholds
// - brownout enabled, reset level 0 default
// - protection only with flash pattern present
// - application programming always allowed
// - level one: no debug, partial programming
// - level two: no debug, full erase only
// - level three: no debug, no programming
// - programming pin entry disable alone
// - pin low boundary scan, high debug
// - debug port off while in reset
// - scan pins switched by hardware
// - scan port gives no debug access
// - four breakpoints, two watchpoints
module rbp_ctrl (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [3:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   input wire logic resetPinN,
   input wire logic watchdogReq,
   input wire logic powerOnDetect,
   input wire logic [3:0] supplyBelow,
   input wire logic [31:0] flashProtWord,
   input wire logic flashInitDone,
   output logic chipReset,
   output logic fastOscEnable,
   output logic flashInitStart,
   output logic [31:0] cpuStartAddr,
   output logic brownoutIrq,
   output logic swdEnable,
   output logic scanMode,
   output logic scanPinMux,
   output logic [1:0] ispCmdSet,
   output logic ispPinEntryEn,
   output logic iapEnable
);
   // ****************************************
   // input synchronisers
   // ****************************************
   logic [5:0] syncA, syncB, syncC, inLevel;
   logic pinHigh, porReq;
   logic [3:0] below;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         syncA <= 6'h3f;
         syncB <= 6'h3f;
         syncC <= 6'h3f;
         inLevel <= 6'h3f;
      end else begin
         syncA <= {powerOnDetect, supplyBelow, resetPinN};
         syncB <= syncA;
         syncC <= syncB;
         // a change counts once stages two and three agree
         inLevel <= (syncB & syncC) | (inLevel & (syncB | syncC));
      end
   end
   assign pinHigh = inLevel[0];
   assign below = inLevel[4:1];
   assign porReq = inLevel[5];

   // ****************************************
   // register file
   // ****************************************
   rbp_pkg::rbp_bodctl_t bodCtl;
   rbp_pkg::rbp_cause_t cause, causeSet;
   rbp_pkg::rbp_seq_t seq, next_seq;
   logic [1:0] protLevel;
   logic noIspPin;
   logic bodRstReq, bodIrqReq, anyReq;
   logic busReq, wrEn;
   logic [31:0] rdData;

   assign busReq = cyc_i && stb_i && !ack_o;
   assign wrEn = busReq && we_i && sel_i[0];
   assign bodRstReq = bodCtl.rstEn && below[bodCtl.rstLvl];
   assign bodIrqReq = bodCtl.irqEn && below[bodCtl.irqLvl];
   assign causeSet = '{brownout_detector: bodRstReq, por: porReq,
                       wdt: watchdogReq, pin: !pinHigh};
   assign anyReq = |causeSet;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         bodCtl <= rbp_pkg::BODCTL_RST;
      end else if (chipReset) begin
         bodCtl <= rbp_pkg::BODCTL_RST;
      end else if (wrEn && adr_i == rbp_pkg::ADR_BODCTL) begin
         bodCtl <= dat_i[5:0];
      end
   end

   // cause flags: write one to clear, a new event wins
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cause <= '0;
      end else if (wrEn && adr_i == rbp_pkg::ADR_STATUS) begin
         cause <= (cause & ~dat_i[rbp_pkg::ST_CAUSE +: 4]) | causeSet;
      end else begin
         cause <= cause | causeSet;
      end
   end

   always_comb begin
      rdData = 32'h0;
      if (adr_i == rbp_pkg::ADR_BODCTL) begin
         rdData[5:0] = bodCtl;
      end else if (adr_i == rbp_pkg::ADR_STATUS) begin
         rdData[rbp_pkg::ST_BODIRQ] = brownoutIrq;
         rdData[rbp_pkg::ST_CAUSE +: 4] = cause;
      end else if (adr_i == rbp_pkg::ADR_PROT) begin
         rdData[1:0] = protLevel;
         rdData[2] = noIspPin;
      end else if (adr_i == rbp_pkg::ADR_DEBUG) begin
         rdData[3:0] = rbp_pkg::NUM_BREAK;
         rdData[7:4] = rbp_pkg::NUM_WATCH;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ack_o <= 1'b0;
         dat_o <= 32'h0;
      end else begin
         ack_o <= busReq;
         dat_o <= (busReq && !we_i) ? rdData : 32'h0;
      end
   end

   // ****************************************
   // reset sequencer
   // ****************************************
   logic [3:0] holdCnt;
   always_comb begin
      next_seq = seq;
      case (seq)
         rbp_pkg::SEQ_PWR: begin
            if (!porReq) begin
               next_seq = rbp_pkg::SEQ_INIT;
            end
         end
         rbp_pkg::SEQ_INIT: begin
            if (!anyReq && flashInitDone) begin
               next_seq = rbp_pkg::SEQ_HOLD;
            end
         end
         rbp_pkg::SEQ_HOLD: begin
            if (holdCnt == rbp_pkg::HOLD_CYC) begin
               next_seq = rbp_pkg::SEQ_RUN;
            end
         end
         default: begin
            next_seq = seq;
         end
      endcase
      if (porReq) begin
         next_seq = rbp_pkg::SEQ_PWR;
      end else if (anyReq && seq != rbp_pkg::SEQ_PWR) begin
         next_seq = rbp_pkg::SEQ_INIT;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         seq <= rbp_pkg::SEQ_PWR;
         holdCnt <= 4'h0;
      end else begin
         seq <= next_seq;
         holdCnt <= (seq == rbp_pkg::SEQ_HOLD) ? holdCnt + 4'h1 : 4'h0;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         chipReset <= 1'b1;
         fastOscEnable <= 1'b0;
         flashInitStart <= 1'b0;
         cpuStartAddr <= rbp_pkg::BOOT_ADDR;
      end else begin
         chipReset <= next_seq != rbp_pkg::SEQ_RUN;
         fastOscEnable <= next_seq != rbp_pkg::SEQ_PWR;
         flashInitStart <= next_seq == rbp_pkg::SEQ_INIT
            && seq != rbp_pkg::SEQ_INIT;
         if (chipReset) begin
            cpuStartAddr <= rbp_pkg::BOOT_ADDR;
         end
      end
   end

   // ****************************************
   // brownout interrupt
   // ****************************************
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         brownoutIrq <= 1'b0;
      end else begin
         brownoutIrq <= bodIrqReq;
      end
   end

   // ****************************************
   // code read protection
   // ****************************************
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         protLevel <= 2'h0;
         noIspPin <= 1'b0;
      end else if (seq == rbp_pkg::SEQ_INIT && flashInitDone) begin
         noIspPin <= flashProtWord == rbp_pkg::PAT_NO_ISP;
         if (flashProtWord == rbp_pkg::PAT_LEVEL1) begin
            protLevel <= 2'h1;
         end else if (flashProtWord == rbp_pkg::PAT_LEVEL2) begin
            protLevel <= 2'h2;
         end else if (flashProtWord == rbp_pkg::PAT_LEVEL3) begin
            protLevel <= 2'h3;
         end else begin
            protLevel <= 2'h0;
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ispCmdSet <= rbp_pkg::ISP_NONE;
         ispPinEntryEn <= 1'b0;
         iapEnable <= 1'b1;
      end else begin
         iapEnable <= 1'b1;
         ispCmdSet <= rbp_pkg::rbp_isp_t'(protLevel);
         ispPinEntryEn <= !noIspPin && protLevel != 2'h3;
      end
   end

   // ****************************************
   // test access selection
   // ****************************************
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         swdEnable <= 1'b0;
         scanMode <= 1'b0;
         scanPinMux <= 1'b0;
      end else begin
         scanMode <= !pinHigh && seq != rbp_pkg::SEQ_PWR;
         scanPinMux <= !pinHigh && seq != rbp_pkg::SEQ_PWR;
         // scan mode never opens the debug port
         swdEnable <= pinHigh && next_seq == rbp_pkg::SEQ_RUN
            && protLevel == 2'h0;
      end
   end

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   a_src_reset: assert property (anyReq |=> chipReset)
      else $error("reset source did not hold chip reset");
   a_fro_flash: assert property ($rose(flashInitStart) |->
      fastOscEnable && chipReset)
      else $error("flash init without oscillator in reset");
   a_pin_pulse: assert property (!pinHigh |=> chipReset [*2])
      else $error("pin low did not reset part");
   a_boot_addr: assert property ($fell(chipReset) |->
      cpuStartAddr == 32'h0)
      else $error("start address not zero at release");
   a_bod_irq: assert property (bodCtl.irqEn && below[bodCtl.irqLvl]
      |=> brownoutIrq)
      else $error("brownout interrupt missing");
   a_bod_read: assert property (busReq && !we_i
      && adr_i == rbp_pkg::ADR_STATUS |=> dat_o[0] == $past(brownoutIrq))
      else $error("status does not show brownout");
   a_bod_dflt: assert property ($fell(chipReset) |->
      bodCtl.rstEn && bodCtl.rstLvl == 2'h0)
      else $error("brownout defaults lost");
   a_prot_swd: assert property (protLevel != 2'h0 |=> !swdEnable)
      else $error("debug open under protection");
   a_rst_swd: assert property (chipReset |-> !swdEnable)
      else $error("debug open during reset");
   a_scan_sel: assert property (!pinHigh && seq != rbp_pkg::SEQ_PWR
      |=> scanMode && scanPinMux && !swdEnable)
      else $error("scan mode not selected");
   a_lvl3_isp: assert property (protLevel == 2'h3 |=>
      !ispPinEntryEn && ispCmdSet == rbp_pkg::ISP_NONE)
      else $error("programming open at level three");
   // ****************************************
   // sequencing, protection and bus checks
   // ****************************************
   a_osc_init: assert property (seq == rbp_pkg::SEQ_INIT |-> fastOscEnable)
      else $error("oscillator off during flash init");
   a_start_pulse: assert property (flashInitStart |=> !flashInitStart)
      else $error("flash init start longer than one cycle");
   a_run_release: assert property (chipReset == (seq != rbp_pkg::SEQ_RUN))
      else $error("chip reset out of step with sequencer");
   a_bod_reset: assert property (bodCtl.rstEn && below[bodCtl.rstLvl]
      |=> chipReset)
      else $error("brownout did not reset chip");
   a_cause_wdt: assert property (watchdogReq |=> cause.wdt)
      else $error("watchdog cause not recorded");
   a_prot_sample: assert property (seq == rbp_pkg::SEQ_INIT
      && flashInitDone && flashProtWord == rbp_pkg::PAT_LEVEL3
      |=> protLevel == 2'h3)
      else $error("protection pattern not taken");
   a_iap_on: assert property (iapEnable)
      else $error("application programming blocked");
   a_lvl1_isp: assert property (protLevel == 2'h1 |=>
      ispCmdSet == rbp_pkg::ISP_PARTIAL && !swdEnable)
      else $error("level one command set wrong");
   a_lvl2_isp: assert property (protLevel == 2'h2 |=>
      ispCmdSet == rbp_pkg::ISP_ERASE_ALL && !swdEnable)
      else $error("level two command set wrong");
   a_no_isp: assert property (noIspPin |=> !ispPinEntryEn)
      else $error("programming pin entry not disabled");
   a_scan_mux: assert property (scanPinMux == scanMode)
      else $error("scan pins not following scan mode");
   a_scan_nodbg: assert property (scanMode |-> !swdEnable)
      else $error("debug open in scan mode");
   a_dbg_count: assert property (busReq && !we_i
      && adr_i == rbp_pkg::ADR_DEBUG |=> dat_o[7:0] == 8'h24)
      else $error("debug resource counts wrong");
   a_ack_follow: assert property (busReq |=> ack_o)
      else $error("bus request not acknowledged");
   a_ack_pulse: assert property (ack_o |=> !ack_o)
      else $error("acknowledge longer than one cycle");
endmodule

`default_nettype wire

// ==== verification/rbp_board.sv ====
// board reset circuit, scan tester and flash controller model
`timescale 1ns/100ps
`default_nettype none
module rbp_board #(
   parameter int INIT_DLY = 6
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic pulseReq,
   input wire logic holdLow,
   input wire logic chipReset,
   input wire logic flashInitStart,
   output logic resetPinN,
   output logic flashInitDone
);
   logic [3:0] pulseCnt;
   logic [3:0] initCnt;
   logic prevRst;
   // pin low for the shortest pulse, or while the tester holds it low
   assign resetPinN = (pulseCnt == 4'h0) && !holdLow;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pulseCnt <= 4'h0;
      end else if (pulseReq) begin
         pulseCnt <= 4'(rbp_pkg::PIN_PULSE_CYC);
      end else if (pulseCnt != 4'h0) begin
         pulseCnt <= pulseCnt - 4'h1;
      end
   end
   // flash controller answers each start late; stale done dropped
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         initCnt <= 4'h0;
         flashInitDone <= 1'b0;
         prevRst <= 1'b1;
      end else begin
         prevRst <= chipReset;
         if (flashInitStart) begin
            initCnt <= 4'(INIT_DLY);
            flashInitDone <= 1'b0;
         end else if (initCnt == 4'h1) begin
            initCnt <= 4'h0;
            flashInitDone <= 1'b1;
         end else if (initCnt != 4'h0) begin
            initCnt <= initCnt - 4'h1;
         end else if (chipReset && !prevRst) begin
            flashInitDone <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// ==== verification/testbench.sv ====
// self-checking bench for the reset and protection controller
`timescale 1ns/100ps
`default_nettype none
module testbench;
   typedef struct packed {
      logic [31:0] word;
      logic [1:0] in_system_programming;
      logic swd;
      logic pinEn;
      logic [2:0] prot;
      logic [2:0] mask;
   } rbp_row_t;
   logic core_clk, rst, cyc_i, stb_i, we_i, watchdogReq, powerOnDetect;
   logic pulseReq, holdLow, resetPinN, flashInitDone, ack_o;
   logic chipReset, fastOscEnable, flashInitStart, brownoutIrq;
   logic swdEnable, scanMode, scanPinMux, ispPinEntryEn, iapEnable;
   logic [3:0] adr_i, sel_i, supplyBelow;
   logic [31:0] dat_i, dat_o, flashProtWord, cpuStartAddr, rd;
   logic [1:0] ispCmdSet;
   logic [2:0] obs;
   int mismatches, numChecks, starts, base;
   rbp_row_t rows [5];
   assign obs = {scanMode, brownoutIrq, chipReset};
   rbp_ctrl DUT (.core_clk, .rst, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
      .dat_i, .dat_o, .ack_o, .resetPinN, .watchdogReq, .powerOnDetect,
      .supplyBelow, .flashProtWord, .flashInitDone, .chipReset,
      .fastOscEnable, .flashInitStart, .cpuStartAddr, .brownoutIrq,
      .swdEnable, .scanMode, .scanPinMux, .ispCmdSet, .ispPinEntryEn,
      .iapEnable);
   rbp_board partner (.core_clk, .rst, .pulseReq, .holdLow, .chipReset,
      .flashInitStart, .resetPinN, .flashInitDone);
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) if (flashInitStart === 1'b1) starts++;
   // ****************************************
   // tasks
   // ****************************************
   task give_verdict;
      $display("checks %0d mismatches %0d", numChecks, mismatches);
      if (mismatches == 0 && numChecks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      numChecks++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task waitFor(input int s, input logic v);
      int n;
      n = 0;
      while (obs[s] !== v) begin
         @(posedge core_clk);
         n++;
         if (n > 300) begin
            mismatches++;
            $display("mismatch at %0t: wait ran out", $time);
            give_verdict;
         end
      end
   endtask
   task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (ack_o !== 1'b1 && n < 20);
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge core_clk);
      if (n >= 20) begin
         mismatches++;
         $display("mismatch at %0t: no bus answer", $time);
         give_verdict;
      end
   endtask
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      {cyc_i, stb_i, we_i, watchdogReq, pulseReq, holdLow} = '0;
      {adr_i, supplyBelow, dat_i, flashProtWord} = '0;
      sel_i = 4'hf;
      powerOnDetect = 1'b1;
      rst = 1'b1;
      rows = '{'{32'h0, 2'h0, 1'b1, 1'b1, 3'h0, 3'h7},
         '{rbp_pkg::PAT_LEVEL1, 2'h1, 1'b0, 1'b1, 3'h1, 3'h7},
         '{rbp_pkg::PAT_LEVEL2, 2'h2, 1'b0, 1'b1, 3'h2, 3'h7},
         '{rbp_pkg::PAT_LEVEL3, 2'h3, 1'b0, 1'b0, 3'h3, 3'h3},
         '{rbp_pkg::PAT_NO_ISP, 2'h0, 1'b1, 1'b0, 3'h4, 3'h7}};
      repeat (2) @(posedge core_clk);
      chk(chipReset, 1'b1);
      chk(swdEnable, 1'b0);
      chk(iapEnable, 1'b1);
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      repeat (10) @(posedge core_clk);
      chk(chipReset, 1'b1);
      powerOnDetect <= 1'b0;
      waitFor(0, 1'b0);
      chk(starts, 1);
      chk(fastOscEnable, 1'b1);
      chk(cpuStartAddr, rbp_pkg::BOOT_ADDR);
      chk(swdEnable, 1'b1);
      bus(1'b0, rbp_pkg::ADR_BODCTL, 32'h0);
      chk(rd, 32'(rbp_pkg::BODCTL_RST));
      bus(1'b0, rbp_pkg::ADR_DEBUG, 32'h0);
      chk(rd, {24'h0, rbp_pkg::NUM_WATCH, rbp_pkg::NUM_BREAK});
      bus(1'b0, 4'h2, 32'h0);
      chk(rd, 32'h0);
      bus(1'b1, rbp_pkg::ADR_PROT, 32'h7);
      bus(1'b0, rbp_pkg::ADR_PROT, 32'h0);
      chk(rd, 32'h0);
      for (int l = 0; l < 4; l++) begin
         bus(1'b1, rbp_pkg::ADR_BODCTL, 32'h20 | (l << 2));
         supplyBelow <= 4'h1 << l;
         waitFor(1, 1'b1);
         bus(1'b0, rbp_pkg::ADR_STATUS, 32'h0);
         chk(rd[rbp_pkg::ST_BODIRQ], 1'b1);
         supplyBelow <= 4'hf ^ (4'h1 << l);
         waitFor(1, 1'b0);
         supplyBelow <= 4'h0;
      end
      for (int l = 0; l < 4; l++) begin
         bus(1'b1, rbp_pkg::ADR_BODCTL, 32'h10 | l);
         supplyBelow <= 4'h1 << l;
         waitFor(0, 1'b1);
         supplyBelow <= 4'h0;
         waitFor(0, 1'b0);
         bus(1'b0, rbp_pkg::ADR_BODCTL, 32'h0);
         chk(rd, 32'(rbp_pkg::BODCTL_RST));
      end
      bus(1'b0, rbp_pkg::ADR_STATUS, 32'h0);
      chk(rd[rbp_pkg::ST_CAUSE + 3], 1'b1);
      watchdogReq <= 1'b1;
      @(posedge core_clk);
      watchdogReq <= 1'b0;
      waitFor(0, 1'b1);
      waitFor(0, 1'b0);
      base = starts;
      foreach (rows[i]) begin
         flashProtWord <= rows[i].word;
         pulseReq <= 1'b1;
         @(posedge core_clk);
         pulseReq <= 1'b0;
         waitFor(0, 1'b1);
         chk(swdEnable, 1'b0);
         waitFor(0, 1'b0);
         chk(ispCmdSet, rows[i].in_system_programming);
         chk(swdEnable, rows[i].swd);
         chk(ispPinEntryEn, rows[i].pinEn);
         chk(iapEnable, 1'b1);
         bus(1'b0, rbp_pkg::ADR_PROT, 32'h0);
         chk(rd[2:0] & rows[i].mask, rows[i].prot);
      end
      chk(starts, base + 5);
      repeat (25000) @(posedge core_clk);
      holdLow <= 1'b1;
      waitFor(2, 1'b1);
      chk(scanPinMux, 1'b1);
      chk(swdEnable, 1'b0);
      chk(chipReset, 1'b1);
      holdLow <= 1'b0;
      waitFor(0, 1'b0);
      chk(scanMode, 1'b0);
      chk(swdEnable, 1'b1);
      give_verdict;
   end
endmodule
`default_nettype wire
